// ### vlc_link_ctrl.sv
// Control registers, loopback, timebase and gating of a VPW link.
// Assumes framing logic on clk supplies symbol events, and an
// AXI4-Lite master reaches the registers; bus_rx is an async pin.
//
// Behaviour
// (R1) Ignore flag disables receiver until SOF/BREAK.
// (R2) After ignore clears, interrupts and status resume.
// (R3) While ignoring, mask all but code 20h.
// (R4) Setting ignore mid-frame discards the rest.
// (R5) Timebase select picks 1.048576 or 1 MHz.
// (R6) Rate code divides crystal by 1/2/4/8.
// (R7) Rate field writable once after reset.
// (R8) Interrupt enable gates requests until sources cleared.
// (R9) Reset clears status; wait exit keeps it.
// (R10) Clearing interrupt enable may drop pending.
// (R11) Wait clock bit stops clocks in wait.
// (R12) Software sets transceiver loopback before analog loopback.
// (R13) Analog loopback resets protocol machine, bus undriven.
// (R14) After analog loopback, EOF before rx, IFS tx.
// (R15) Digital loopback returns transmit to receive input.
// (R16) Digital loopback suppresses bus edge wakeup.
// (R17) After digital loopback, idle EOF/IFS before use.
// (R18) Software never toggles digital loopback mid-transmit.
// (R19) Software sets receive polarity before digital loopback.
// (R20) Fast bit: receive only 41.6k, else 10.4k.
// (R21) BREAK clears fast bit, loads status 1Ch.
// (R22) Without fast bit, 4X frames are noise.
// (R23) Plain control bits read back as written.
// (R24) Control two resets with both loopbacks set.
`timescale 1ns/1ps
module vlc_link_ctrl
  import vlc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              sof_seen,
  input  wire logic              break_seen,
  input  wire logic              eof_idle,
  input  wire logic              ifs_idle,
  input  wire logic              rx_busy,
  input  wire logic              fast_frame,
  input  wire logic              sv_load,
  input  wire logic [7:0]        sv_code,
  input  wire logic              tx_data_in,
  input  wire logic              bus_rx,
  input  wire logic              cpu_wait,
  output logic                   irq,
  output logic                   wakeup_irq,
  output logic                   rx_enable,
  output logic                   tx_enable,
  output logic                   link_tick,
  output logic                   clk_run,
  output logic                   timebase_binary,
  output logic                   fast_mode,
  output logic                   noise_frame,
  output logic                   sm_reset,
  output logic                   msg_discard,
  output logic                   rx_data,
  output logic                   bus_tx,
  output logic                   bus_tx_oe
);

  initial begin
    if (ADDR_W < 4) begin
      $error("ADDR_W too small for the register map.");
    end
  end

  // Register state.
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] sv;
  logic       rate_locked;
  logic       alb_q;
  logic       rx_ok;
  logic       tx_ok;
  logic [2:0] div_cnt;

  // Bus state.
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;

  // Pin synchroniser.
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;

  // Field aliases.
  wire ign    = ctrl1[C1_IGN];
  wire irq_en = ctrl1[C1_IRQ];
  wire wcs    = ctrl1[C1_WCS];
  wire alb    = ctrl2[C2_ALB];
  wire dlb    = ctrl2[C2_DLB];
  wire fast   = ctrl2[C2_FAST];
  wire [1:0] rate = {ctrl1[C1_RHI], ctrl1[C1_RLO]};

  // Write channel decode.
  wire aw_now  = s_axi_awvalid & s_axi_awready;
  wire w_now   = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held | aw_now;
  wire w_have  = w_held | w_now;
  wire wr_go   = aw_have & w_have & ~s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr
                                      : s_axi_awaddr;
  wire [7:0] wr_byte = w_held ? w_byte : s_axi_wdata[7:0];
  wire       wr_lane = w_held ? w_lane0 : s_axi_wstrb[0];
  wire wr_c1 = wr_go & wr_lane & (wr_addr == OFS_CTRL1);
  wire wr_c2 = wr_go & wr_lane & (wr_addr == OFS_CTRL2);
  wire wr_map = (wr_addr == OFS_CTRL1)
              | (wr_addr == OFS_CTRL2)
              | (wr_addr == OFS_SVEC);

  // Read channel decode.
  wire rd_go  = s_axi_arvalid & s_axi_arready;
  wire rd_sv  = rd_go & (s_axi_araddr == OFS_SVEC);
  wire rd_map = (s_axi_araddr == OFS_CTRL1)
              | (s_axi_araddr == OFS_CTRL2)
              | (s_axi_araddr == OFS_SVEC);
  wire [7:0] rd_byte =
    (s_axi_araddr == OFS_CTRL1) ? ctrl1 :
    (s_axi_araddr == OFS_CTRL2) ? ctrl2 :
    (s_axi_araddr == OFS_SVEC)  ? sv    : 8'h00;

  // Software sets of self-clearing bits win over hardware clears.
  wire ign_wr_set  = wr_c1 & wr_byte[C1_IGN];
  wire fast_wr_set = wr_c2 & wr_byte[C2_FAST];
  wire en_drop     = wr_c1 & irq_en & ~wr_byte[C1_IRQ];

  // Next control one.
  wire [7:0] next_ctrl1_raw = wr_c1 ? wr_byte : ctrl1;
  wire       next_ign = ign_wr_set
                      | (next_ctrl1_raw[C1_IGN]
                         & ~(sof_seen | break_seen)); // [R1]
  wire [1:0] next_rate = (wr_c1 & ~rate_locked)
                       ? {wr_byte[C1_RHI], wr_byte[C1_RLO]}
                       : rate; // [R7]
  wire [7:0] next_ctrl1 = {next_ign,
                           next_ctrl1_raw[C1_TBS],
                           next_rate,
                           next_ctrl1_raw[3:0]}; // [R23]

  // Next control two.
  wire [7:0] next_ctrl2_raw = wr_c2 ? wr_byte : ctrl2;
  wire next_fast = fast_wr_set
                 | (next_ctrl2_raw[C2_FAST] & ~break_seen); // [R21]
  wire [7:0] next_ctrl2 = {next_ctrl2_raw[7:6],
                           next_fast,
                           next_ctrl2_raw[4:0]}; // [R23]

  // State vector update.
  wire sv_pass   = ~ign | (sv_code == SV_IGN_OK); // [R3]
  wire sv_take   = sv_load & sv_pass; // [R2]
  wire sv_clear  = rd_sv | en_drop | ign_wr_set; // [R10]
  wire [7:0] next_sv =
    break_seen ? SV_BREAK : // [R21]
    sv_take    ? sv_code  :
    (sv_clear | (ign & (sv != SV_IGN_OK))) ? SV_RESET : sv; // [R3]

  // Loopback release and idle qualification.
  wire lb_any   = alb | dlb;
  wire lb_drop  = (ctrl2[C2_ALB] & ~next_ctrl2[C2_ALB])
                | (ctrl2[C2_DLB] & ~next_ctrl2[C2_DLB]);
  wire next_rx_ok = lb_drop ? 1'b0
                  : (rx_ok | eof_idle); // [R14] [R17]
  wire next_tx_ok = lb_drop ? 1'b0
                  : (tx_ok | (ifs_idle & rx_ok)); // [R14] [R17]

  // Timebase divider.
  wire [2:0] div_max = 3'((DIV_ONE << rate) - DIV_ONE); // [R6]
  wire       run_now = ~(cpu_wait & wcs); // [R11]
  wire       div_end = (div_cnt >= div_max);
  wire [2:0] next_div = (div_end | ~run_now) ? CNT_ZERO
                                             : div_cnt + 3'h1;

  // Interrupt request.
  wire irq_src = (sv != SV_RESET)
               & (~ign | (sv == SV_IGN_OK)); // [R3]
  wire next_irq = irq_en & ~cpu_wait & irq_src; // [R8] [R9]

  // Bus interface registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      aw_held <= aw_have & ~wr_go;
      w_held  <= w_have & ~wr_go;
      if (aw_now) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_now) begin
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      s_axi_awready <= ~aw_have | wr_go;
      s_axi_wready  <= ~w_have | wr_go;
      if (wr_go) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_map ? RESP_OK : RESP_ERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_map ? RESP_OK : RESP_ERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Control and status registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1       <= CTRL1_RST;
      ctrl2       <= CTRL2_RST; // [R24]
      sv          <= SV_RESET; // [R9]
      rate_locked <= 1'b0;
      alb_q       <= 1'b1;
      rx_ok       <= 1'b0;
      tx_ok       <= 1'b0;
    end else begin
      ctrl1       <= next_ctrl1;
      ctrl2       <= next_ctrl2;
      sv          <= next_sv;
      rate_locked <= rate_locked | wr_c1; // [R7]
      alb_q       <= alb;
      rx_ok       <= next_rx_ok;
      tx_ok       <= next_tx_ok;
    end
  end

  // Pin synchroniser; the second and third stages feed logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_prev <= 1'b0;
    end else begin
      rx_meta <= bus_rx;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Outputs toward the protocol machine and the pin.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq             <= 1'b0;
      wakeup_irq      <= 1'b0;
      rx_enable       <= 1'b0;
      tx_enable       <= 1'b0;
      link_tick       <= 1'b0;
      clk_run         <= 1'b1;
      timebase_binary <= 1'b0;
      fast_mode       <= 1'b0;
      noise_frame     <= 1'b0;
      sm_reset        <= 1'b0;
      msg_discard     <= 1'b0;
      rx_data         <= TX_PASSIVE;
      bus_tx          <= TX_PASSIVE;
      bus_tx_oe       <= 1'b0;
      div_cnt         <= CNT_ZERO;
    end else begin
      irq             <= next_irq;
      wakeup_irq      <= ~dlb & (rx_sync ^ rx_prev); // [R16]
      rx_enable       <= ~ign & rx_ok & ~lb_any; // [R1]
      tx_enable       <= tx_ok & ~lb_any & ~fast; // [R20]
      div_cnt         <= next_div;
      link_tick       <= div_end & run_now; // [R6] [R11]
      clk_run         <= run_now; // [R11]
      timebase_binary <= ctrl1[C1_TBS]; // [R5]
      fast_mode       <= fast; // [R20]
      noise_frame     <= fast_frame & ~fast; // [R22]
      sm_reset        <= alb & ~alb_q; // [R13]
      msg_discard     <= ign_wr_set & rx_busy; // [R4]
      rx_data         <= dlb ? tx_data_in : rx_sync; // [R15]
      bus_tx          <= lb_any ? TX_PASSIVE : tx_data_in;
      bus_tx_oe       <= ~lb_any & tx_ok; // [R13] [R15]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ign_rx_off_a: assert property ( // [R1]
    ign |=> !rx_enable)
    else $error("Receiver enabled while ignoring.");

  ign_clear_a: assert property ( // [R1]
    (sof_seen || break_seen) && !ign_wr_set |=> !ign)
    else $error("Ignore flag not cleared by frame start.");

  sv_hold_a: assert property ( // [R3]
    ign && sv != SV_IGN_OK && sv_load && sv_code != SV_IGN_OK
    && !break_seen
    |=> sv == SV_RESET)
    else $error("Status changed while ignoring.");

  rate_lock_a: assert property ( // [R7]
    rate_locked |=> $stable(rate))
    else $error("Rate field changed after lock.");

  brk_fast_a: assert property ( // [R21]
    break_seen && !fast_wr_set |=> !fast && sv == SV_BREAK)
    else $error("Break did not clear fast mode.");

  dl_mux_a: assert property ( // [R15]
    dlb |=> rx_data == $past(tx_data_in))
    else $error("Loopback data not returned.");

  dl_wake_a: assert property ( // [R16]
    dlb |=> !wakeup_irq)
    else $error("Wakeup raised in digital loopback.");

  al_reset_a: assert property ( // [R13]
    $rose(alb) |=> sm_reset ##1 !sm_reset)
    else $error("Analog loopback gave no reset pulse.");

  lb_tx_a: assert property ( // [R17]
    lb_drop |=> !tx_ok ##1 !tx_enable)
    else $error("Transmit allowed right after loopback.");

  irq_mask_a: assert property ( // [R8]
    !irq_en |=> !irq)
    else $error("Interrupt raised while disabled.");

  wait_clk_a: assert property ( // [R11]
    cpu_wait && wcs |=> !clk_run && !link_tick)
    else $error("Clocks ran in wait with stop set.");

  fast_tx_a: assert property ( // [R20]
    fast |=> !tx_enable)
    else $error("Transmit enabled in fast receive.");

endmodule

// ### vlc_pkg.sv
// Package for the link control register slice.
// Assumes an AXI4-Lite master with 32-bit data on the register side.
package vlc_pkg;
  localparam int ADDR_W = 4;
  // Register byte offsets.
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h4;
  localparam logic [3:0] OFS_SVEC  = 4'h8;
  // Control one field positions.
  localparam int C1_IGN  = 7;
  localparam int C1_TBS  = 6;
  localparam int C1_RHI  = 5;
  localparam int C1_RLO  = 4;
  localparam int C1_IRQ  = 1;
  localparam int C1_WCS  = 0;
  // Control two field positions.
  localparam int C2_ALB  = 7;
  localparam int C2_DLB  = 6;
  localparam int C2_FAST = 5;
  // Reset values.
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'hC0;
  localparam logic [7:0] SV_RESET  = 8'h00;
  // State vector codes.
  localparam logic [7:0] SV_IGN_OK = 8'h20;
  localparam logic [7:0] SV_BREAK  = 8'h1C;
  // Timebase rates in Hz and divider constants.
  localparam int TB_BIN_HZ = 1048576;
  localparam int TB_INT_HZ = 1000000;
  localparam logic [3:0] DIV_ONE  = 4'h1;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  // Bus answers.
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Passive level of the link transmit line.
  localparam logic TX_PASSIVE = 1'b0;
endpackage

// ### vlc_xcvr_model.sv
// Transceiver and bus model on the far side of the link control slice.
// Assumes a passive-low bus with a pull-down and one other node on it.
`timescale 1ns/1ps
module vlc_xcvr_model (
  input  wire logic bus_tx,
  input  wire logic bus_tx_oe,
  input  wire logic other_node,
  input  wire logic xcvr_loop,
  output logic      bus_rx
);
  // In loopback the drive stage input returns to the receiver.
  // Otherwise the wire is the OR of all drivers, low when all release.
  // Received data is passed on without inversion.
  assign bus_rx = xcvr_loop ? bus_tx : ((bus_tx_oe & bus_tx) | other_node);
endmodule

// ### vlc_link_ctrl_tb.sv
// Self-checking testbench for the link control register slice.
// Assumes the package and the transceiver model are compiled first.
`timescale 1ns/1ps
module vlc_link_ctrl_tb
  import vlc_pkg::*;
;
  logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, sof_seen, break_seen, eof_idle;
  logic        ifs_idle, rx_busy, fast_frame, sv_load, tx_data_in, cpu_wait;
  logic        clr, other_node, xcvr_loop, bus_rx, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq, wakeup_irq, rx_enable, tx_enable, link_tick, clk_run;
  logic        timebase_binary, fast_mode, noise_frame, sm_reset;
  logic        msg_discard, rx_data, bus_tx, bus_tx_oe;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, hit;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [7:0]  sv_code, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          mismatches, check_count, n;

  vlc_link_ctrl vlc_link_ctrl_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sof_seen, .break_seen, .eof_idle, .ifs_idle, .rx_busy, .fast_frame,
    .sv_load, .sv_code, .tx_data_in, .bus_rx, .cpu_wait, .irq, .wakeup_irq,
    .rx_enable, .tx_enable, .link_tick, .clk_run, .timebase_binary,
    .fast_mode, .noise_frame, .sm_reset, .msg_discard, .rx_data, .bus_tx,
    .bus_tx_oe);
  vlc_xcvr_model vlc_xcvr_model_i (.bus_tx, .bus_tx_oe, .other_node,
    .xcvr_loop, .bus_rx);

  always #4 clk = ~clk;

  // Catches one-cycle pulses so that a scenario can judge them afterwards.
  always @(posedge clk) begin
    hit <= (clr | rst) ? 4'h0
         : hit | {sm_reset, msg_discard, noise_frame, wakeup_irq};
  end

  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task bus(input bit w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!w && s_axi_rvalid) begin
        r = s_axi_rresp;
        q = s_axi_rdata[7:0];
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      mismatches++;
      conclude();
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("read", q, e);
  endtask

  task st;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task hc;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  // Pulses one framing event: sof, break, eof, ifs, fast frame, load.
  task ev(input int k, input logic [7:0] c);
    @(posedge clk);
    {sof_seen, break_seen, eof_idle, ifs_idle, fast_frame, sv_load} <=
      6'h20 >> k;
    sv_code <= c;
    @(posedge clk);
    {sof_seen, break_seen, eof_idle, ifs_idle, fast_frame, sv_load} <= 6'h0;
    st();
  endtask

  task toggle_bus;
    repeat (8) begin
      @(posedge clk);
      other_node <= ~other_node;
      repeat (3) @(posedge clk);
    end
    st();
  endtask

  task t_reset;
    rd(OFS_CTRL1, CTRL1_RST);
    rd(OFS_CTRL2, 8'hC0);
    rd(OFS_SVEC, 8'h00);
    bus(1'b0, 4'hC, 8'h00);
    chk("rresp", r, RESP_ERR);
    bus(1'b1, 4'hC, 8'hFF);
    chk("bresp", r, RESP_ERR);
    chk("oe", bus_tx_oe, 1'b0);
  endtask

  task t_rate;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wr(OFS_CTRL1, {2'b01, c[1:0], 4'h0});
      rd(OFS_CTRL1, {2'b01, c[1:0], 4'h0});
      chk("tbase", timebase_binary, 1'b1);
      wr(OFS_CTRL1, 8'h00);
      rd(OFS_CTRL1, {2'b00, c[1:0], 4'h0});
      chk("tbase", timebase_binary, 1'b0);
      n = 0;
      repeat (64) begin
        @(posedge clk);
        #1;
        n += link_tick;
      end
      chk("ticks", n, 64 >> c);
    end
  endtask

  task t_loop;
    @(posedge clk);
    tx_data_in <= 1'b1;
    st();
    chk("rxd", rx_data, 1'b1);
    chk("btx", bus_tx, 1'b0);
    hc();
    toggle_bus();
    chk("wake", hit[0], 1'b0);
    wr(OFS_CTRL2, 8'h00);
    st();
    chk("rxen", rx_enable, 1'b0);
    ev(2, 8'h00);
    chk("rxen", rx_enable, 1'b1);
    chk("txen", tx_enable, 1'b0);
    ev(3, 8'h00);
    chk("txen", tx_enable, 1'b1);
    chk("oe", bus_tx_oe, 1'b1);
    chk("btx", bus_tx, 1'b1);
    @(posedge clk) tx_data_in <= 1'b0;
    hc();
    toggle_bus();
    chk("wake", hit[0], 1'b1);
    @(posedge clk);
    xcvr_loop <= 1'b1;
    hc();
    wr(OFS_CTRL2, 8'h80);
    st();
    chk("smrst", hit[3], 1'b1);
    chk("oe", bus_tx_oe, 1'b0);
    wr(OFS_CTRL2, 8'h00);
    ev(3, 8'h00);
    chk("txen", tx_enable, 1'b0);
    ev(2, 8'h00);
    ev(3, 8'h00);
    chk("txen", tx_enable, 1'b1);
    @(posedge clk) xcvr_loop <= 1'b0;
  endtask

  task t_fast;
    wr(OFS_CTRL2, 8'h20);
    st();
    chk("fast", fast_mode, 1'b1);
    chk("txen", tx_enable, 1'b0);
    hc();
    ev(4, 8'h00);
    chk("noise", hit[1], 1'b0);
    ev(1, 8'h00);
    chk("fast", fast_mode, 1'b0);
    chk("txen", tx_enable, 1'b1);
    rd(OFS_CTRL2, 8'h00);
    rd(OFS_SVEC, SV_BREAK);
    ev(4, 8'h00);
    chk("noise", hit[1], 1'b1);
  endtask

  task t_irq;
    wr(OFS_CTRL1, 8'h02);
    ev(5, 8'h05);
    chk("irq", irq, 1'b1);
    @(posedge clk) cpu_wait <= 1'b1;
    st();
    chk("irq", irq, 1'b0);
    @(posedge clk) cpu_wait <= 1'b0;
    st();
    chk("irq", irq, 1'b1);
    rd(OFS_SVEC, 8'h05);
    st();
    chk("irq", irq, 1'b0);
    ev(5, 8'h06);
    wr(OFS_CTRL1, 8'h00);
    rd(OFS_SVEC, 8'h00);
  endtask

  task t_ign;
    wr(OFS_CTRL1, 8'h82);
    st();
    chk("rxen", rx_enable, 1'b0);
    ev(5, 8'h05);
    rd(OFS_SVEC, SV_RESET);
    ev(5, SV_IGN_OK);
    chk("irq", irq, 1'b1);
    rd(OFS_SVEC, SV_IGN_OK);
    ev(0, 8'h00);
    rd(OFS_CTRL1, 8'h32);
    ev(5, 8'h05);
    chk("irq", irq, 1'b1);
    rd(OFS_SVEC, 8'h05);
    rx_busy <= 1'b1;
    hc();
    wr(OFS_CTRL1, 8'h82);
    st();
    chk("discard", hit[2], 1'b1);
    @(posedge clk) rx_busy <= 1'b0;
  endtask

  task t_wait;
    wr(OFS_CTRL1, 8'h01);
    cpu_wait <= 1'b1;
    st();
    chk("clkrun", clk_run, 1'b0);
    @(posedge clk) cpu_wait <= 1'b0;
    wr(OFS_CTRL1, 8'h00);
    cpu_wait <= 1'b1;
    st();
    chk("clkrun", clk_run, 1'b1);
    @(posedge clk) cpu_wait <= 1'b0;
  endtask

  initial begin
    {clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, sof_seen, break_seen, eof_idle, ifs_idle, rx_busy} = '0;
    {fast_frame, sv_load, tx_data_in, cpu_wait, clr, other_node} = '0;
    {xcvr_loop, s_axi_awaddr, s_axi_araddr, s_axi_wdata, sv_code} = '0;
    {mismatches, check_count} = '0;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rate();
    t_loop();
    t_fast();
    t_irq();
    t_ign();
    t_wait();
    conclude();
  end
endmodule
